// ### shared/ivrc_pkg.sv
package ivrc_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int PIN_RST_MIN_NS = 200;
   localparam int PIN_RST_CYC =
      (PIN_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LS_BIT_PS = 666667;
   localparam int SE0_MIN_BITS = 4;
   localparam int SE0_MIN_CYC =
      (SE0_MIN_BITS * LS_BIT_PS + CLK_PERIOD_NS * 1000 - 1)
      / (CLK_PERIOD_NS * 1000);
   localparam int USB_RST_CYC = 24;
   localparam int STARTUP_TIMEOUT_CYC = 64;

   // ==========================================================
   // Sources and vectors
   localparam int USB_EVT_N = 5;
   localparam int SPRS_EVT_N = 4;
   localparam int SEP_BIT = 3;
   localparam int N_VEC = 8;
   localparam int USB_VEC_IDX = 7;
   localparam logic [11:0] VEC_RESET = 12'h000;
   localparam logic [11:0] VEC_ADDR [N_VEC] = '{
      12'h002, 12'h004, 12'h006, 12'h008,
      12'h00a, 12'h00c, 12'h00e, 12'h018};

   // ==========================================================
   // Register map, byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_IRQ_EN = 8'h04;
   localparam logic [7:0] OFS_IRQ_FLAG = 8'h08;
   localparam logic [7:0] OFS_USB_FLAG = 8'h0c;
   localparam logic [7:0] OFS_USB_EN = 8'h10;
   localparam logic [7:0] OFS_USB_MASK = 8'h14;
   localparam logic [7:0] OFS_SPRS_FLAG = 8'h18;
   localparam logic [7:0] OFS_SPRS_EN = 8'h1c;
   localparam logic [7:0] OFS_SPRS_MASK = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### src/level_qualifier.sv
`timescale 1ns/10ps
`default_nettype none
module level_qualifier #(
   parameter int CYC = 10
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Level in, qualified level out
   input wire logic level,
   output logic held
);
   localparam int W = $clog2(CYC + 1);
   localparam logic [W-1:0] TOP = W'(CYC);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic held;
   } st_t;
   st_t st_q, st_d;

   // ==========================================================
   // Counts consecutive high samples; short glitches are dropped
   always_comb begin
      st_d = st_q;
      if (!level) begin
         st_d.cnt = '0;
      end else if (st_q.cnt != TOP) begin
         st_d.cnt = st_q.cnt + W'(1);
      end
      st_d.held = level && (st_d.cnt == TOP);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign held = st_q.held;
endmodule
`default_nettype wire

// ### src/release_delay.sv
`timescale 1ns/10ps
`default_nettype none
module release_delay #(
   parameter int CYC = 64
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Hold request, delayed release
   input wire logic hold,
   output logic active
);
   localparam int W = $clog2(CYC + 1);
   localparam logic [W-1:0] TOP = W'(CYC);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic active;
   } st_t;
   st_t st_q, st_d;

   // ==========================================================
   // timeout after release
   always_comb begin
      st_d = st_q;
      if (hold) begin
         st_d.cnt = '0;
      end else if (st_q.cnt != TOP) begin
         st_d.cnt = st_q.cnt + W'(1);
      end
      st_d.active = hold || (st_d.cnt != TOP);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '{cnt: '0, active: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   assign active = st_q.active;
endmodule
`default_nettype wire

// ### src/interrupt_vector_reset_control.sv
// What this block does
// - Fifteen sources on few vectors; nine USB sources share two vectors.
// - Request needs its own enable and the global enable both set.
// - Lowest vector address wins; reset first, then suspend/resume.
// - Pin, power-on and watchdog resets all vector to address zero.
// - Suspend/resume goes to 0x002, external request one to 0x004.
// - Timer capture, match A/B, overflows go to 0x006 through 0x00e.
// - USB events reach vectors 13 and 2 via flag, enable, mask.
// - Frame events in one set, bus reset and suspend in another.
// - USB event with enable clear is never captured, lost for good.
// - Masked captured USB event waits, fires once unmasked.
// - Reset pin low over 200 ns always resets the processor.
// - Enabled watchdog timeout resets the processor.
// - Separation active when suspend/resume enable bit 3 is one.
// - Bus reset seen after SE0 of four low-speed bit times.
// - Bus reset pulse to USB and processor lasts 24 clocks.
// - Without separation, bus reset resets processor too.
// - With separation only USB resets; interrupt if mask bit 3 set.
// - USB reset returns the USB side to unconfigured state.
// - Processor reset clears registers and vectors fetch to zero.
// - At power-up a delay counter holds processor in reset.
// - After pin release, wait for the startup timeout.
// - Watchdog gives one-clock pulse; timeout counts from its end.
// - Accept clears global enable; return-from-interrupt sets it.
// - Vectoring clears the peripheral flag that caused it; USB and suspend/resume flags stay set.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module interrupt_vector_reset_control
   import ivrc_pkg::*;
#(
   parameter int USB_N = USB_EVT_N,
   parameter int SPRS_N = SPRS_EVT_N,
   parameter int STARTUP_CYC = STARTUP_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Event pulses: ext one, capture, match A, match B, ovf1, ovf0
   input wire logic [5:0] periph_evt,
   input wire logic [USB_N-1:0] usb_evt,
   input wire logic [SPRS_N-1:0] sprs_evt,
   // Processor core
   output logic irq_req,
   output logic [11:0] irq_vector,
   input wire logic irq_ack,
   input wire logic reti,
   output logic cpu_reset,
   // Reset sources
   input wire logic reset_pin_n,
   input wire logic wdt_enable,
   input wire logic wdt_timeout,
   input wire logic upstream_se0,
   output logic usb_reset
);
   typedef struct packed {
      logic gie;
      logic [N_VEC-1:0] irq_en;
      logic [N_VEC-2:0] irq_flag;
      logic [USB_N-1:0] usb_flag;
      logic [USB_N-1:0] usb_en;
      logic [USB_N-1:0] usb_mask;
      logic [SPRS_N-1:0] sprs_flag;
      logic [SPRS_N-1:0] sprs_en;
      logic [SPRS_N-1:0] sprs_mask;
      logic irq_req;
      logic [11:0] irq_vec;
      logic [2:0] sel;
      logic wdt_pulse;
      logic busrst_seen;
      logic [4:0] usb_cnt;
      logic usb_rst;
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [7:0] aw_addr;
      logic [7:0] wdata;
      logic wen;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } st_t;

   st_t st_q, st_d;
   logic pin_low_long;
   logic se0_long;
   logic cpu_rst;
   logic cpu_hold;
   logic sep;
   logic busrst_rise;
   logic ack;
   logic [N_VEC-1:0] pend;

   // ==========================================================
   // Reset sources
   // pin low qualifier
   level_qualifier #(.CYC(PIN_RST_CYC)) u_pin_qual (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(!reset_pin_n),
      .held(pin_low_long)
   );

   level_qualifier #(.CYC(SE0_MIN_CYC)) u_se0_qual (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(upstream_se0),
      .held(se0_long)
   );

   assign sep = st_q.sprs_en[SEP_BIT];
   assign busrst_rise = se0_long && !st_q.busrst_seen;
   // any source keeps the hold; shared bus reset
   assign cpu_hold = pin_low_long || st_q.wdt_pulse
      || (st_q.usb_rst && !sep);

   // timeout starts after the pulse ends
   release_delay #(.CYC(STARTUP_CYC)) u_startup (
      .aclk(aclk),
      .aresetn(aresetn),
      .hold(cpu_hold),
      .active(cpu_rst)
   );

   assign ack = irq_ack && st_q.irq_req;

   // ==========================================================
   // Pending requests
   always_comb begin
      pend[N_VEC-2:0] = st_q.irq_flag & st_q.irq_en[N_VEC-2:0];
      // masked USB events wait in their flags; vector 13
      pend[USB_VEC_IDX] = st_q.irq_en[USB_VEC_IDX]
         && |(st_q.usb_flag & st_q.usb_mask);
   end

   // ==========================================================
   // Next state
   always_comb begin
      logic [N_VEC-2:0] flag_clr;
      logic [N_VEC-2:0] flag_set;
      logic [USB_N-1:0] usb_clr;
      logic [SPRS_N-1:0] sprs_clr;
      logic [SPRS_N-1:0] sprs_set;
      logic do_wr;
      logic [7:0] wv;
      logic [2:0] pick;
      logic found;
      flag_clr = '0;
      flag_set = '0;
      usb_clr = '0;
      sprs_clr = '0;
      sprs_set = '0;
      do_wr = 1'b0;
      wv = st_q.wdata;
      pick = 3'h0;
      found = 1'b0;
      st_d = st_q;

      // AXI write: address and data in either order
      if (st_q.awready && s_axi_awvalid) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = s_axi_awaddr[7:0];
      end
      if (st_q.wready && s_axi_wvalid) begin
         st_d.w_held = 1'b1;
         st_d.wdata = s_axi_wdata[7:0];
         st_d.wen = s_axi_wstrb[0];
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.aw_held && st_q.w_held) begin
         do_wr = st_q.wen;
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = RESP_OKAY;
         unique case (st_q.aw_addr)
            OFS_CTRL: if (do_wr) st_d.gie = wv[0];
            OFS_IRQ_EN: if (do_wr) st_d.irq_en = wv[N_VEC-1:0];
            OFS_IRQ_FLAG: if (do_wr) flag_clr = wv[N_VEC-2:0];
            OFS_USB_FLAG: if (do_wr) usb_clr = wv[USB_N-1:0];
            OFS_USB_EN: if (do_wr) st_d.usb_en = wv[USB_N-1:0];
            OFS_USB_MASK: if (do_wr) st_d.usb_mask = wv[USB_N-1:0];
            OFS_SPRS_FLAG: if (do_wr) sprs_clr = wv[SPRS_N-1:0];
            OFS_SPRS_EN: if (do_wr) st_d.sprs_en = wv[SPRS_N-1:0];
            OFS_SPRS_MASK: if (do_wr) st_d.sprs_mask = wv[SPRS_N-1:0];
            OFS_STATUS: ;
            default: st_d.bresp = RESP_SLVERR;
         endcase
      end
      st_d.awready = !st_d.aw_held && !st_d.bvalid;
      st_d.wready = !st_d.w_held && !st_d.bvalid;

      // AXI read
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (st_q.arready && s_axi_arvalid) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = RESP_OKAY;
         st_d.rdata = 32'h0;
         unique case (s_axi_araddr[7:0])
            OFS_CTRL: st_d.rdata[0] = st_q.gie;
            OFS_IRQ_EN: st_d.rdata[N_VEC-1:0] = st_q.irq_en;
            OFS_IRQ_FLAG: st_d.rdata[N_VEC-2:0] = st_q.irq_flag;
            OFS_USB_FLAG: st_d.rdata[USB_N-1:0] = st_q.usb_flag;
            OFS_USB_EN: st_d.rdata[USB_N-1:0] = st_q.usb_en;
            OFS_USB_MASK: st_d.rdata[USB_N-1:0] = st_q.usb_mask;
            OFS_SPRS_FLAG: st_d.rdata[SPRS_N-1:0] = st_q.sprs_flag;
            OFS_SPRS_EN: st_d.rdata[SPRS_N-1:0] = st_q.sprs_en;
            OFS_SPRS_MASK: st_d.rdata[SPRS_N-1:0] = st_q.sprs_mask;
            OFS_STATUS: st_d.rdata = {4'h0, st_q.irq_vec, 13'h0,
               st_q.irq_req, st_q.usb_rst, cpu_rst};
            default: st_d.rresp = RESP_SLVERR;
         endcase
      end
      st_d.arready = !st_d.rvalid;

      // enabled watchdog timeout, one clock wide
      st_d.wdt_pulse = wdt_timeout && wdt_enable;

      st_d.busrst_seen = se0_long;
      if (busrst_rise) begin
         st_d.usb_cnt = 5'(USB_RST_CYC);
      end else if (st_q.usb_cnt != 5'h0) begin
         st_d.usb_cnt = st_q.usb_cnt - 5'h1;
      end
      st_d.usb_rst = st_d.usb_cnt != 5'h0;

      // only enabled USB events are captured; two groups
      // bus reset flag only captured under separation
      sprs_set = sprs_evt & st_q.sprs_en;
      sprs_set[SEP_BIT] = busrst_rise && sep;
      // Set beats clear so an event in the clearing cycle survives
      st_d.usb_flag = (st_q.usb_flag & ~usb_clr)
         | (usb_evt & st_q.usb_en);
      st_d.sprs_flag = (st_q.sprs_flag & ~sprs_clr) | sprs_set;

      // Suspend/resume vector raised by its group's unmasked flags
      flag_set = {periph_evt, |(st_q.sprs_flag & st_q.sprs_mask)};

      for (int i = N_VEC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            pick = 3'(i);
            found = 1'b1;
         end
      end

      // acceptance drops the global enable, return restores it
      if (ack) begin
         st_d.gie = 1'b0;
         if (st_q.sel != 3'(USB_VEC_IDX)) begin
            flag_clr[st_q.sel] = 1'b1;
         end
      end else if (reti) begin
         st_d.gie = 1'b1;
      end
      st_d.irq_flag = (st_q.irq_flag & ~flag_clr) | flag_set;

      st_d.irq_req = st_q.gie && found && !cpu_rst && !ack;
      st_d.sel = pick;
      st_d.irq_vec = VEC_ADDR[pick];

      // USB reset returns frame registers to defaults
      if (st_q.usb_rst) begin
         st_d.usb_flag = '0;
         st_d.usb_en = '0;
         st_d.usb_mask = '0;
      end
      // processor reset clears registers; vector zero
      if (cpu_rst) begin
         st_d.gie = 1'b0;
         st_d.irq_en = '0;
         st_d.irq_flag = '0;
         st_d.sprs_flag = '0;
         st_d.sprs_en = '0;
         st_d.sprs_mask = '0;
         st_d.irq_req = 1'b0;
         st_d.irq_vec = VEC_RESET;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Outputs
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign s_axi_rvalid = st_q.rvalid;
   assign irq_req = st_q.irq_req;
   assign irq_vector = st_q.irq_vec;
   assign cpu_reset = cpu_rst;
   assign usb_reset = st_q.usb_rst;

   // ==========================================================
   // Checks
   logic [5:0] usb_len_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         usb_len_q <= 6'h0;
      end else if (st_q.usb_rst) begin
         usb_len_q <= usb_len_q + 6'h1;
      end else begin
         usb_len_q <= 6'h0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_reset_vector: assert property (
      cpu_rst |=> irq_vector == VEC_RESET && !irq_req)
      else $error("vector not zero during reset");
   chk_global_gate: assert property (
      $rose(irq_req) |-> $past(st_q.gie) && !$past(cpu_rst))
      else $error("request without global enable");
   chk_ack_gie: assert property (
      irq_ack && irq_req && !cpu_rst |=> !st_q.gie && !irq_req)
      else $error("accept did not clear global enable");
   chk_reti_gie: assert property (
      reti && !(irq_ack && irq_req) && !cpu_rst |=> st_q.gie)
      else $error("return did not set global enable");
   chk_usb_pulse_len: assert property (
      $fell(st_q.usb_rst) |-> usb_len_q == 6'(USB_RST_CYC))
      else $error("bus reset pulse length wrong");
   chk_usb_enable: assert property (
      (st_q.usb_flag & ~$past(st_q.usb_flag) & ~$past(st_q.usb_en))
      == '0)
      else $error("disabled USB event captured");
   chk_usb_masked: assert property (
      irq_req && irq_vector == VEC_ADDR[USB_VEC_IDX]
      |-> $past(|(st_q.usb_flag & st_q.usb_mask)))
      else $error("masked USB event interrupted");
   chk_prio_first: assert property (
      $past(st_q.gie && pend[0] && !cpu_rst && !ack) |->
      irq_req && irq_vector == VEC_ADDR[0])
      else $error("suspend/resume did not win");
   chk_joint_reset: assert property (
      $rose(st_q.usb_rst) && !sep |-> ##[1:2] cpu_rst)
      else $error("bus reset missed processor");
   chk_wdt_reset: assert property (
      wdt_timeout && wdt_enable |-> ##[1:3] cpu_rst)
      else $error("watchdog did not reset");
   chk_ack_flag: assert property (
      ack && !cpu_rst && irq_vector == VEC_ADDR[1] && !periph_evt[0]
      |=> !st_q.irq_flag[1])
      else $error("flag not cleared on vectoring");

   cov_usb_vector: cover property (
      irq_ack && irq_req && irq_vector == VEC_ADDR[USB_VEC_IDX]);
   cov_sep_busrst: cover property ($rose(st_q.usb_rst) && sep);
   cov_wdt_reset: cover property (st_q.wdt_pulse ##1 cpu_rst);
endmodule
`default_nettype wire

// ### test/core_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Request side
   input wire logic irq_req,
   input wire logic [11:0] irq_vector,
   input wire logic slow,
   // Core answers
   output logic irq_ack,
   output logic reti,
   output logic [11:0] last_vec,
   output int n_acc
);
   // ==========================================
   // Vector fetch and handler return
   int wait_c;
   int reti_c;
   always_ff @(posedge aclk) begin
      irq_ack <= 1'b0;
      reti <= 1'b0;
      if (!aresetn) begin
         wait_c <= 0;
         reti_c <= 0;
         n_acc <= 0;
         last_vec <= 12'hfff;
      end else if (reti_c > 0) begin
         // Handler runs long enough for software to clear its flags
         reti_c <= reti_c - 1;
         reti <= (reti_c == 1);
      end else if (irq_req && !irq_ack) begin
         if (slow && wait_c < 3) begin
            wait_c <= wait_c + 1;
         end else begin
            irq_ack <= 1'b1;
            last_vec <= irq_vector;
            n_acc <= n_acc + 1;
            wait_c <= 0;
            reti_c <= 30;
         end
      end
   end
endmodule
`default_nettype wire

// ### test/tb_interrupt_vector_reset_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_vector_reset_control;
   import ivrc_pkg::*;
   localparam int SU = 4;
   logic aclk = 0, aresetn = 0;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, irq_req, irq_ack, reti, cpu_reset;
   logic [5:0] periph_evt;
   logic [USB_EVT_N-1:0] usb_evt;
   logic [SPRS_EVT_N-1:0] sprs_evt;
   logic reset_pin_n, wdt_enable, wdt_timeout, upstream_se0;
   logic usb_reset, slow;
   logic [11:0] irq_vector, last_vec;
   int n_acc, n_mismatch, samples_checked, cyc, n, b;

   always #10 aclk = ~aclk;

   interrupt_vector_reset_control #(.STARTUP_CYC(SU))
      interrupt_vector_reset_control_i (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .periph_evt, .usb_evt, .sprs_evt, .irq_req, .irq_vector, .irq_ack,
      .reti, .cpu_reset, .reset_pin_n, .wdt_enable, .wdt_timeout,
      .upstream_se0, .usb_reset);
   core_model core_model_i (.aclk, .aresetn, .irq_req, .irq_vector,
      .slow, .irq_ack, .reti, .last_vec, .n_acc);

   // ==========================================
   // Checking and bus tasks
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 0;
      w = 0;
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      chk(rd, e);
   endtask
   // Waits for the core to take a vector beyond acceptance count b
   task automatic exp_vec(input int b, input logic [11:0] v);
      repeat (60) if (n_acc == b) @(posedge aclk);
      chk(last_vec, v);
   endtask
   task automatic rel(input int lo, input int hi);
      n = 0;
      while (cpu_reset !== 1'b0 && n < 300) begin
         @(posedge aclk);
         n++;
      end
      chk(n >= lo && n <= hi, 1);
   endtask
   task automatic se0(input int k);
      upstream_se0 <= 1'b1;
      tick(k);
      upstream_se0 <= 1'b0;
   endtask

   // ==========================================
   // Timeout, far above the under two thousand cycles the run needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict;
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      {periph_evt, usb_evt, sprs_evt} = '0;
      {wdt_enable, wdt_timeout, upstream_se0, slow} = '0;
      reset_pin_n = 1'b1;
      tick(6);
      chk(irq_vector, VEC_RESET);
      aresetn <= 1'b1;
      rel(SU, SU + 2);
      wr(OFS_CTRL, 1);
      wr(OFS_IRQ_EN, 32'hff);
      chk(rs, RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
         periph_evt <= 6'h1 << i;
         tick(1);
         periph_evt <= 6'h0;
         exp_vec(n_acc, VEC_ADDR[i+1]);
         rchk(OFS_IRQ_FLAG, 0);
         rchk(OFS_CTRL, 0);
         tick(30);
         rchk(OFS_CTRL, 1);
      end
      rchk(8'h3c, 0);
      chk(rs, RESP_SLVERR);
      wr(8'h3c, 0);
      chk(rs, RESP_SLVERR);
      // Write with the low byte lane off must leave the register alone
      s_axi_wstrb <= 4'h0;
      wr(OFS_CTRL, 0);
      s_axi_wstrb <= 4'hf;
      chk(rs, RESP_OKAY);
      rchk(OFS_CTRL, 1);
      wr(OFS_IRQ_EN, 0);
      periph_evt <= 6'h3f;
      tick(1);
      periph_evt <= 6'h0;
      tick(4);
      chk(irq_req, 0);
      slow <= 1'b1;
      b = n_acc;
      wr(OFS_IRQ_EN, 32'hff);
      for (int i = 0; i < 6; i++) exp_vec(b + i, VEC_ADDR[i+1]);
      slow <= 1'b0;
      // Let the last handler return so the mask check below can trip
      tick(35);
      usb_evt <= 1;
      tick(1);
      usb_evt <= 0;
      tick(2);
      rchk(OFS_USB_FLAG, 0);
      wr(OFS_USB_EN, 32'h1f);
      usb_evt <= 2;
      tick(1);
      usb_evt <= 0;
      tick(4);
      chk(irq_req, 0);
      rchk(OFS_USB_FLAG, 2);
      b = n_acc;
      wr(OFS_USB_MASK, 32'h1f);
      exp_vec(b, VEC_ADDR[USB_VEC_IDX]);
      wr(OFS_USB_FLAG, 32'h1f);
      tick(35);
      chk(irq_req, 0);
      wr(OFS_SPRS_EN, 32'h7);
      wr(OFS_SPRS_MASK, 32'hf);
      sprs_evt <= 1;
      tick(1);
      sprs_evt <= 0;
      exp_vec(n_acc, VEC_ADDR[0]);
      rchk(OFS_SPRS_FLAG, 1);
      wr(OFS_SPRS_FLAG, 32'hf);
      wr(OFS_IRQ_FLAG, 32'hff);
      tick(30);
      se0(SE0_MIN_CYC - 1);
      tick(3);
      chk(usb_reset, 0);
      se0(SE0_MIN_CYC);
      n = 0;
      while (usb_reset !== 1'b1 && n < 9) begin
         @(posedge aclk);
         n++;
      end
      n = 0;
      while (usb_reset === 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      chk(n, USB_RST_CYC);
      chk(cpu_reset, 1);
      rel(1, SU + 2);
      wr(OFS_CTRL, 1);
      wr(OFS_IRQ_EN, 1);
      wr(OFS_USB_EN, 32'h1f);
      wr(OFS_SPRS_EN, 32'h8);
      wr(OFS_SPRS_MASK, 32'h8);
      se0(SE0_MIN_CYC);
      exp_vec(n_acc, VEC_ADDR[0]);
      rchk(OFS_STATUS, {4'h0, VEC_ADDR[0], 16'h2});
      chk(cpu_reset, 0);
      rchk(OFS_SPRS_FLAG, 8);
      wr(OFS_SPRS_FLAG, 32'hf);
      wr(OFS_IRQ_FLAG, 32'hff);
      rchk(OFS_USB_EN, 0);
      tick(30);
      wdt_timeout <= 1'b1;
      tick(1);
      wdt_timeout <= 1'b0;
      tick(3);
      chk(cpu_reset, 0);
      wdt_enable <= 1'b1;
      wdt_timeout <= 1'b1;
      tick(1);
      wdt_timeout <= 1'b0;
      tick(2);
      chk(cpu_reset, 1);
      rel(SU - 2, SU + 2);
      wdt_enable <= 1'b0;
      wr(OFS_CTRL, 1);
      reset_pin_n <= 1'b0;
      tick(PIN_RST_CYC - 1);
      reset_pin_n <= 1'b1;
      tick(3);
      chk(cpu_reset, 0);
      reset_pin_n <= 1'b0;
      tick(PIN_RST_CYC);
      reset_pin_n <= 1'b1;
      tick(3);
      chk(cpu_reset, 1);
      chk(irq_vector, VEC_RESET);
      rel(1, SU + 4);
      rchk(OFS_CTRL, 0);
      print_verdict;
   end
endmodule
`default_nettype wire
